// File: include/msg_unit_consts.svh
`ifndef MSG_UNIT_CONSTS_SVH
`define MSG_UNIT_CONSTS_SVH

// register byte offsets inside the a-side window
`define ADDR_MSB          7
`define OFS_TX_WORD3      8'h0c
`define OFS_RX_WORD0      8'h10
`define OFS_STATUS        8'h20
`define OFS_INT_STATUS    8'h24
`define OFS_INT_MASK      8'h28

// a-side status and interrupt bit positions
`define AST_RX_FULL0      0
`define AST_TX_EMPTY3     1
`define INT_RX_FULL0      0
`define INT_TX_EMPTY3     1

// b-side status bit positions
`define BST_RX_FULL3      0
`define BST_TX_EMPTY0     1

// reset values
`define RST_WORD          32'h0000_0000
`define RST_MASK          32'h0000_0000

// ahb-lite encodings
`define HTRANS_ACTIVE_BIT 1
`define HRESP_OKAY        1'b0
`define HRESP_ERROR       1'b1

`endif

// File: include/msg_unit_pkg.sv
package msg_unit_pkg;

  // bus response sequencer: two-cycle error answer
  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_ERR_WAIT = 2'b01,
    ST_ERR_DONE = 2'b10
  } resp_state_e;

endpackage : msg_unit_pkg

// File: src/msg_channel.sv
`timescale 1ns/1ps
`include "msg_unit_consts.svh"

module msg_channel
  import msg_unit_pkg::*;
(
  input  logic        clk_sys,
  input  logic        rst,
  input  logic        wr_stb,
  input  logic [31:0] wr_data,
  input  logic        rd_stb,
  output logic [31:0] word,
  output logic        rx_full,
  output logic        tx_empty
);

  // single word, no second stage: a new write simply overwrites
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      word <= `RST_WORD;
    end else if (wr_stb) begin
      word <= wr_data;
    end
  end

  // a write wins over a read in the same cycle, the new word is unread
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_full  <= 1'b0;
      tx_empty <= 1'b1;
    end else if (wr_stb) begin
      rx_full  <= 1'b1;
      tx_empty <= 1'b0;
    end else if (rd_stb) begin
      rx_full  <= 1'b0;
      tx_empty <= 1'b1;
    end
  end

endmodule : msg_channel

// File: src/ahb_reg_port.sv
`timescale 1ns/1ps
`include "msg_unit_consts.svh"

module ahb_reg_port
  import msg_unit_pkg::*;
(
  input  logic                 clk_sys,
  input  logic                 rst,
  input  logic                 hsel,
  input  logic [31:0]          haddr,
  input  logic [1:0]           htrans,
  input  logic                 hwrite,
  input  logic                 hready,
  input  logic [31:0]          hwdata,
  output logic                 hreadyout,
  output logic                 hresp,
  output logic [31:0]          hrdata,
  input  logic [31:0]          rd_data,
  output logic [`ADDR_MSB:0]   rd_addr,
  output logic                 rd_stb,
  output logic                 wr_stb,
  output logic [`ADDR_MSB:0]   wr_addr,
  output logic [31:0]          wr_data
);

  resp_state_e state;
  resp_state_e next_state;
  logic        accept;
  logic        reject;
  logic        wr_pend;

  // address phase taken only while the bus is ready
  assign accept  = hsel && hready && htrans[`HTRANS_ACTIVE_BIT];
  assign reject  = accept && hwrite && (haddr[`ADDR_MSB:0] == `OFS_RX_WORD0);
  assign rd_addr = haddr[`ADDR_MSB:0];
  assign rd_stb  = accept && !hwrite;
  assign wr_stb  = wr_pend;
  assign wr_data = hwdata;

  // error answer is one wait cycle then one ready cycle, both with error
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE, ST_ERR_DONE: begin
        next_state = reject ? ST_ERR_WAIT : ST_IDLE;
      end
      ST_ERR_WAIT: begin
        next_state = ST_ERR_DONE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign hreadyout = (state != ST_ERR_WAIT);
  assign hresp     = (state == ST_IDLE) ? `HRESP_OKAY : `HRESP_ERROR;

  // writes complete in the data phase, when hwdata stands
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_addr <= '0;
    end else begin
      wr_pend <= accept && hwrite && !reject;
      if (accept) begin
        wr_addr <= haddr[`ADDR_MSB:0];
      end
    end
  end

  // read data registered at the address edge: zero wait states
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      hrdata <= `RST_WORD;
    end else if (rd_stb) begin
      hrdata <= rd_data;
    end
  end

endmodule : ahb_reg_port

// File: src/messaging_unit.sv
`timescale 1ns/1ps
`include "msg_unit_consts.svh"


module messaging_unit
  import msg_unit_pkg::*;
(
  input  logic        clk_sys,
  input  logic        rst,
  input  logic        hsel,
  input  logic [31:0] haddr,
  input  logic [1:0]  htrans,
  input  logic        hwrite,
  input  logic [2:0]  hsize,
  input  logic [31:0] hwdata,
  input  logic        hready,
  output logic        hreadyout,
  output logic        hresp,
  output logic [31:0] hrdata,
  output logic        irq_a,
  input  logic        b_tx_word0_wr,
  input  logic [31:0] b_tx_word0_data,
  input  logic        b_rx_word3_rd,
  input  logic        b_rx_irq_en3,
  input  logic        b_tx_irq_en0,
  output logic [31:0] b_side_rx_word3,
  output logic [31:0] b_side_status_reg,
  output logic        b_rx_irq3,
  output logic        b_tx_irq0
);

  logic [`ADDR_MSB:0] rd_addr;
  logic [`ADDR_MSB:0] wr_addr;
  logic               rd_stb;
  logic               wr_stb;
  logic [31:0]        wr_data;
  logic [31:0]        rd_data;
  logic               wr_tx3;
  logic               wr_mask;
  logic               rd_rx0;
  logic               rd_int;
  logic [31:0]        word0;
  logic               rx_full0;
  logic               tx_empty0;
  logic               rx_full3;
  logic               tx_empty3;
  logic [31:0]        a_side_status_reg;
  logic [31:0]        int_status;
  logic [31:0]        int_set;
  logic [31:0]        int_mask;

  // offset compare shared by the read and write decoders
  function automatic logic hit(input logic [`ADDR_MSB:0] addr,
                               input logic [`ADDR_MSB:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  // bus front end; hsize is not decoded, only whole words are carried
  ahb_reg_port u_port (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .hwdata    (hwdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .hrdata    (hrdata),
    .rd_data   (rd_data),
    .rd_addr   (rd_addr),
    .rd_stb    (rd_stb),
    .wr_stb    (wr_stb),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data)
  );

  // register strobes
  assign wr_tx3  = wr_stb && hit(wr_addr, `OFS_TX_WORD3);
  assign wr_mask = wr_stb && hit(wr_addr, `OFS_INT_MASK);
  assign rd_rx0  = rd_stb && hit(rd_addr, `OFS_RX_WORD0);
  assign rd_int  = rd_stb && hit(rd_addr, `OFS_INT_STATUS);

  // a to b channel, word 3
  msg_channel u_ch3 (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .wr_stb   (wr_tx3),
    .wr_data  (wr_data),
    .rd_stb   (b_rx_word3_rd),
    .word     (b_side_rx_word3),
    .rx_full  (rx_full3),
    .tx_empty (tx_empty3)
  );

  // b to a channel, word 0
  msg_channel u_ch0 (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .wr_stb   (b_tx_word0_wr),
    .wr_data  (b_tx_word0_data),
    .rd_stb   (rd_rx0),
    .word     (word0),
    .rx_full  (rx_full0),
    .tx_empty (tx_empty0)
  );

  // status views built from the live flags of every channel, so any
  // write or read leaves both sides consistent in the same cycle
  always_comb begin
    a_side_status_reg                 = '0;
    a_side_status_reg[`AST_RX_FULL0]  = rx_full0;
    a_side_status_reg[`AST_TX_EMPTY3] = tx_empty3;
    b_side_status_reg                 = '0;
    b_side_status_reg[`BST_RX_FULL3]  = rx_full3;
    b_side_status_reg[`BST_TX_EMPTY0] = tx_empty0;
  end

  // read mux; the transmit word is write-only and reads as zero
  always_comb begin
    case (rd_addr)
      `OFS_RX_WORD0: begin
        rd_data = word0;
      end
      `OFS_STATUS: begin
        rd_data = a_side_status_reg;
      end
      `OFS_INT_STATUS: begin
        rd_data = int_status;
      end
      `OFS_INT_MASK: begin
        // a mask write still in its data phase is forwarded to a read behind it
        rd_data = wr_mask ? wr_data : int_mask;
      end
      default: begin
        rd_data = '0;
      end
    endcase
  end

  // a-side events: b delivered word 0, b consumed word 3
  always_comb begin
    int_set                 = '0;
    int_set[`INT_RX_FULL0]  = b_tx_word0_wr;
    int_set[`INT_TX_EMPTY3] = b_rx_word3_rd;
  end

  // sticky bits cleared by reading them; a set in that cycle survives
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      int_status <= '0;
    end else if (rd_int) begin
      int_status <= int_set;
    end else begin
      int_status <= int_status | int_set;
    end
  end

  // mask has the layout of the sticky register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      int_mask <= `RST_MASK;
    end else if (wr_mask) begin
      int_mask <= wr_data;
    end
  end

  assign irq_a = |(int_status & int_mask);

  // b-side requests are registered levels, one cycle behind the flags
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      b_rx_irq3 <= 1'b0;
      b_tx_irq0 <= 1'b0;
    end else begin
      b_rx_irq3 <= rx_full3 && b_rx_irq_en3;
      b_tx_irq0 <= tx_empty0 && b_tx_irq_en0;
    end
  end

  // write to word 3 shows on the b side after the data-phase edge
  chk_tx3_reflect : assert property (@(posedge clk_sys) disable iff (rst)
    wr_tx3 |=> (b_side_rx_word3 == $past(wr_data)))
    else $error("word 3 not reflected to b side");

  // word 3 cannot be read back by a
  chk_tx3_write_only : assert property (@(posedge clk_sys) disable iff (rst)
    (rd_stb && hit(rd_addr, `OFS_TX_WORD3)) |=> (hrdata == 32'h0000_0000))
    else $error("word 3 readable on a side");

  // overwrite of an unread word keeps full and takes the new value
  chk_no_double_buf : assert property (@(posedge clk_sys) disable iff (rst)
    (wr_tx3 && rx_full3) |=> (rx_full3 && b_side_rx_word3 == $past(wr_data)))
    else $error("unread word 3 not overwritten");

  // flag pair moves together on a word 3 write
  chk_tx3_flags : assert property (@(posedge clk_sys) disable iff (rst)
    wr_tx3 |=> (!a_side_status_reg[`AST_TX_EMPTY3] && b_side_status_reg[`BST_RX_FULL3]))
    else $error("word 3 flags not updated by write");

  // enabled receive request follows within two edges
  chk_rx3_irq : assert property (@(posedge clk_sys) disable iff (rst)
    (wr_tx3 && b_rx_irq_en3) ##1 b_rx_irq_en3 |=> b_rx_irq3)
    else $error("receive irq 3 not raised");

  // no request while the enable is off
  chk_rx3_irq_off : assert property (@(posedge clk_sys) disable iff (rst)
    !$past(b_rx_irq_en3) |-> !b_rx_irq3)
    else $error("receive irq 3 without enable");

  // status of the other channel stays current across a word 3 write
  chk_status_refresh : assert property (@(posedge clk_sys) disable iff (rst)
    (wr_tx3 && b_tx_word0_wr) |=>
      (a_side_status_reg[`AST_RX_FULL0] && !b_side_status_reg[`BST_TX_EMPTY0]))
    else $error("status not refreshed on write");

  // read of word 0 returns the whole 32-bit word
  chk_rx0_read : assert property (@(posedge clk_sys) disable iff (rst)
    rd_rx0 |=> (hrdata == $past(word0)))
    else $error("word 0 read data wrong");

  // b write visible on a after one edge, with full set
  chk_rx0_visible : assert property (@(posedge clk_sys) disable iff (rst)
    b_tx_word0_wr |=> (word0 == $past(b_tx_word0_data) && rx_full0))
    else $error("word 0 not visible on a side");

  // write to word 0 gets the two-cycle error answer
  chk_rx0_wr_error : assert property (@(posedge clk_sys) disable iff (rst)
    (hsel && hready && htrans[`HTRANS_ACTIVE_BIT] && hwrite &&
     hit(haddr[`ADDR_MSB:0], `OFS_RX_WORD0))
      |=> (!hreadyout && hresp) ##1 (hreadyout && hresp))
    else $error("write to word 0 not rejected");

  // rejected write leaves the word untouched
  chk_rx0_no_write : assert property (@(posedge clk_sys) disable iff (rst)
    (!hreadyout && !$past(b_tx_word0_wr)) |-> $stable(word0))
    else $error("word 0 changed by rejected write");

  // reads elsewhere never consume word 0
  chk_rx0_decode : assert property (@(posedge clk_sys) disable iff (rst)
    (rd_stb && !hit(rd_addr, `OFS_RX_WORD0) && rx_full0) |=> rx_full0)
    else $error("word 0 consumed by other offset");

  // read of word 0 frees the b transmitter
  chk_rx0_consume : assert property (@(posedge clk_sys) disable iff (rst)
    (rd_rx0 && !b_tx_word0_wr) |=> (!rx_full0 && b_side_status_reg[`BST_TX_EMPTY0]))
    else $error("word 0 read did not update flags");

  // enabled transmit request follows the read
  chk_tx0_irq : assert property (@(posedge clk_sys) disable iff (rst)
    (rd_rx0 && !b_tx_word0_wr && b_tx_irq_en0) ##1 (b_tx_irq_en0 && !b_tx_word0_wr)
      |=> b_tx_irq0)
    else $error("transmit irq 0 not raised");

  // an event in the clearing read cycle is kept
  chk_int_set_wins : assert property (@(posedge clk_sys) disable iff (rst)
    (rd_int && b_tx_word0_wr) |=> int_status[`INT_RX_FULL0])
    else $error("event lost on clearing read");

  // interrupt line stays low while the whole mask is clear
  chk_irq_a_masked : assert property (@(posedge clk_sys) disable iff (rst)
    (int_mask == 32'h0000_0000) |-> !irq_a)
    else $error("irq asserted while fully masked");

endmodule : messaging_unit

// File: sim/b_proc_model.sv
`timescale 1ns/1ps

// behavioural stand-in for the second processor on the b side
module b_proc_model
  import msg_unit_pkg::*;
(
  input  logic        clk_sys,
  input  logic        rst,
  input  logic [31:0] b_side_rx_word3,
  output logic        b_tx_word0_wr,
  output logic [31:0] b_tx_word0_data,
  output logic        b_rx_word3_rd,
  output logic        b_rx_irq_en3,
  output logic        b_tx_irq_en0
);
  // quiet at time zero; data bus carries no meaning outside a write pulse
  initial begin
    b_tx_word0_wr   = 1'b0;
    b_tx_word0_data = 32'h5a5a_a5a5;
    b_rx_word3_rd   = 1'b0;
    b_rx_irq_en3    = 1'b0;
    b_tx_irq_en0    = 1'b0;
  end

  // one-cycle write of word 0, optionally after a stall
  task automatic send_word0(input logic [31:0] d, input int stall);
    repeat (stall) @(posedge clk_sys);
    @(posedge clk_sys);
    b_tx_word0_wr   <= 1'b1;
    b_tx_word0_data <= d;
    @(posedge clk_sys);
    b_tx_word0_wr   <= 1'b0;
    b_tx_word0_data <= ~d; // released: inverse so a stale value never passes
  endtask : send_word0

  // one-cycle read of word 3; the word is taken in the cycle of the pulse
  task automatic take_word3(output logic [31:0] v);
    @(posedge clk_sys);
    b_rx_word3_rd <= 1'b1;
    @(negedge clk_sys);
    v = b_side_rx_word3;
    @(posedge clk_sys);
    b_rx_word3_rd <= 1'b0;
  endtask : take_word3

  // interrupt enables are levels on this side
  task automatic set_en(input logic e3, input logic e0);
    @(posedge clk_sys);
    b_rx_irq_en3 <= e3;
    b_tx_irq_en0 <= e0;
  endtask : set_en
endmodule : b_proc_model

// File: sim/tb_top.sv
`timescale 1ns/1ps
`include "msg_unit_consts.svh"

module tb_top import msg_unit_pkg::*;;
  typedef struct packed {
    logic        err;
    logic        wr;
    logic [31:0] data;
  } exp_s;
  localparam logic [31:0] A_TX3 = {24'h00, `OFS_TX_WORD3};
  localparam logic [31:0] A_RX0 = {24'h00, `OFS_RX_WORD0};
  localparam logic [31:0] A_ST  = {24'h00, `OFS_STATUS};
  localparam logic [31:0] A_IST = {24'h00, `OFS_INT_STATUS};
  localparam logic [31:0] A_MSK = {24'h00, `OFS_INT_MASK};
  localparam logic [31:0] F0    = 32'h1 << `AST_RX_FULL0;
  localparam logic [31:0] E3    = 32'h1 << `AST_TX_EMPTY3;
  localparam logic [31:0] F3    = 32'h1 << `BST_RX_FULL3;
  localparam logic [31:0] E0    = 32'h1 << `BST_TX_EMPTY0;
  localparam logic [31:0] I0    = 32'h1 << `INT_RX_FULL0;
  localparam logic [31:0] I3    = 32'h1 << `INT_TX_EMPTY3;

  logic        clk_sys, rst, hsel, hwrite, hready, hreadyout, hresp, irq_a;
  logic [31:0] haddr, hwdata, hrdata, b_tx_word0_data, b_side_rx_word3, b_side_status_reg;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        b_tx_word0_wr, b_rx_word3_rd, b_rx_irq_en3, b_tx_irq_en0;
  logic        b_rx_irq3, b_tx_irq0, ph;
  logic [31:0] d, v;
  int          err_count = 0;
  int          n_compared = 0;
  exp_s        exp_q[$];

  assign hready = hreadyout; // the only slave drives the bus ready

  // free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  messaging_unit i_dut (
    .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq_a(irq_a),
    .b_tx_word0_wr(b_tx_word0_wr), .b_tx_word0_data(b_tx_word0_data),
    .b_rx_word3_rd(b_rx_word3_rd), .b_rx_irq_en3(b_rx_irq_en3),
    .b_tx_irq_en0(b_tx_irq_en0), .b_side_rx_word3(b_side_rx_word3),
    .b_side_status_reg(b_side_status_reg), .b_rx_irq3(b_rx_irq3), .b_tx_irq0(b_tx_irq0));

  b_proc_model i_b (
    .clk_sys(clk_sys), .rst(rst), .b_side_rx_word3(b_side_rx_word3),
    .b_tx_word0_wr(b_tx_word0_wr), .b_tx_word0_data(b_tx_word0_data),
    .b_rx_word3_rd(b_rx_word3_rd), .b_rx_irq_en3(b_rx_irq_en3),
    .b_tx_irq_en0(b_tx_irq_en0));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  // returns at the rising edge where hready is sampled high; a hung bus ends the run
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) begin
      chk("hready", 32'h1, 32'(hready));
      complete_run();
    end
  endtask : wait_ready

  // one single word transfer; the expectation is queued for the monitor
  task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] wd,
                     input logic [31:0] ed, input logic ee);
    exp_q.push_back('{err: ee, wr: w, data: ed});
    @(posedge clk_sys);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
  endtask : ahb

  // tracks a pending data phase on the bus
  always @(posedge clk_sys) begin
    if (rst) ph <= 1'b0;
    else if (hsel && htrans[1] && hreadyout) ph <= 1'b1;
    else if (hreadyout) ph <= 1'b0;
  end

  // a finished data phase takes the oldest note off the queue
  always @(negedge clk_sys) begin
    if (ph && hreadyout === 1'b1) begin
      if (exp_q.size() == 0) chk("unexpected transfer", 32'h0, 32'h1);
      else begin
        chk("hresp", 32'(exp_q[0].err), 32'(hresp));
        if (!exp_q[0].wr) chk("hrdata", exp_q[0].data, hrdata);
        void'(exp_q.pop_front());
      end
    end
  end

  // hang guard, far beyond the fewer than a hundred cycles of the sequence
  initial begin
    #(25 * 5000);
    err_count++;
    complete_run();
  end

  // main sequence
  initial begin
    rst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = 32'h0;
    void'($urandom(7128));
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk("b_status", E0, b_side_status_reg);
    ahb(A_ST, 1'b0, 32'h0, E3, 1'b0);
    ahb(A_TX3, 1'b0, 32'h0, 32'h0, 1'b0);
    ahb(32'h40, 1'b0, 32'h0, 32'h0, 1'b0);
    ahb(A_MSK, 1'b1, I0 | I3, 32'h0, 1'b0);
    ahb(A_MSK, 1'b0, 32'h0, I0 | I3, 1'b0);
    i_b.set_en(1'b1, 1'b1);
    // two writes with no read between: the newest must win
    for (int k = 0; k < 2; k++) begin
      d = $urandom;
      ahb(A_TX3, 1'b1, d, 32'h0, 1'b0);
    end
    @(negedge clk_sys);
    chk("b_word3", d, b_side_rx_word3);
    // b transmitter for word 0 is still empty from reset
    chk("b_status", F3 | E0, b_side_status_reg);
    ahb(A_ST, 1'b0, 32'h0, 32'h0, 1'b0);
    @(negedge clk_sys);
    chk("b_rx_irq3", 32'h1, 32'(b_rx_irq3));
    i_b.take_word3(v);
    chk("b_read_word3", d, v);
    @(negedge clk_sys);
    chk("b_status", E0, b_side_status_reg);
    chk("irq_a", 32'h1, 32'(irq_a));
    ahb(A_IST, 1'b0, 32'h0, I3, 1'b0);
    @(negedge clk_sys);
    chk("irq_a", 32'h0, 32'(irq_a));
    // b side sends word 0 after a stall
    d = $urandom;
    i_b.send_word0(d, 2);
    @(negedge clk_sys);
    chk("b_status", 32'h0, b_side_status_reg);
    chk("irq_a", 32'h1, 32'(irq_a));
    // a touches word 0 only after seeing its full flag set
    ahb(A_ST, 1'b0, 32'h0, F0 | E3, 1'b0);
    // a write to the full receive word is refused and changes nothing
    ahb(A_RX0, 1'b1, ~d, 32'h0, 1'b1);
    @(negedge clk_sys);
    chk("b_tx_irq0", 32'h0, 32'(b_tx_irq0));
    ahb(A_RX0, 1'b0, 32'h0, d, 1'b0);
    @(negedge clk_sys);
    chk("b_status", E0, b_side_status_reg);
    chk("b_tx_irq0", 32'h1, 32'(b_tx_irq0));
    ahb(A_ST, 1'b0, 32'h0, E3, 1'b0);
    ahb(A_IST, 1'b0, 32'h0, I0, 1'b0);
    // masked and disabled interrupts stay low; the b write lands on the
    // same edge as the a write, so both status views must move together
    ahb(A_MSK, 1'b1, 32'h0, 32'h0, 1'b0);
    i_b.set_en(1'b0, 1'b0);
    d = $urandom;
    fork
      i_b.send_word0(d, 1);
      ahb(A_TX3, 1'b1, $urandom, 32'h0, 1'b0);
    join
    repeat (2) @(negedge clk_sys);
    chk("b_status", F3, b_side_status_reg);
    chk("irq_a", 32'h0, 32'(irq_a));
    chk("b_rx_irq3", 32'h0, 32'(b_rx_irq3));
    ahb(A_IST, 1'b0, 32'h0, I0, 1'b0);
    ahb(A_RX0, 1'b0, 32'h0, d, 1'b0);
    repeat (2) @(negedge clk_sys);
    complete_run();
  end
endmodule : tb_top
